// file: common/ctx_consts.vh
`ifndef CTX_CONSTS_VH
`define CTX_CONSTS_VH

// reset values of the processor-visible state
`define CTX_PC_RST 16'h0000
`define CTX_SP_RST 16'h0000
`define CTX_PSW_RST 16'h0000

// carry flag position in the status word
`define CTX_C_BIT 0

// stack and vector word step in bytes
`define CTX_WORD_STEP 16'h0002

// vector used when a jump names register mode 0
`define CTX_VEC_ILLEGAL 16'h0004

// opcode match patterns
`define CTX_OP_BLO 8'h87
`define CTX_OP_JMP 10'h001
`define CTX_OP_JSR 7'h04
`define CTX_OP_RTS 13'h0010
`define CTX_OP_SOB 7'h3F
`define CTX_OP_RTI 16'h0002
`define CTX_OP_RTT 16'h0006

// destination mode codes
`define CTX_MODE_REG 3'h0
`define CTX_MODE_DEFER 3'h1

`endif

// file: logic/ctx_exec.v
`timescale 1ns/100ps
`include "ctx_consts.vh"
module ctx_exec (
  // clock and reset
  input wire clock,
  input wire reset_n,
  // instruction and trap requests
  input wire instr_valid,
  input wire [15:0] instr_word,
  input wire [15:0] instr_pc,
  input wire [15:0] dst_addr,
  input wire trap_req,
  input wire [15:0] trap_vec,
  // memory for code, stack and vectors
  output reg mem_req,
  output reg mem_we,
  output reg [15:0] mem_addr,
  output reg [15:0] mem_wdata,
  input wire [15:0] mem_rdata,
  input wire mem_ack,
  // status
  output reg busy,
  output reg done,
  output reg illegal,
  output reg [15:0] pc,
  output reg [15:0] sp,
  output reg [15:0] psw
);
  localparam [8:0] S_IDLE = 9'h001;
  localparam [8:0] S_TPUSH_PS = 9'h002;
  localparam [8:0] S_TPUSH_PC = 9'h004;
  localparam [8:0] S_VEC_PC = 9'h008;
  localparam [8:0] S_VEC_PS = 9'h010;
  localparam [8:0] S_POP_PC = 9'h020;
  localparam [8:0] S_POP_PS = 9'h040;
  localparam [8:0] S_JSR_PUSH = 9'h080;
  localparam [8:0] S_RTS_POP = 9'h100;

  reg [8:0] state_r;
  reg [15:0] tmp_r;
  reg [15:0] vec_r;
  reg [2:0] link_r;

  wire accept = ~busy & (instr_valid | trap_req);
  wire take_trap = accept & trap_req;
  wire take_instr = accept & ~trap_req;
  wire acked = mem_req & mem_ack;

  wire is_blo = instr_word[15:8] == `CTX_OP_BLO;
  wire is_jmp = instr_word[15:6] == `CTX_OP_JMP;
  wire is_jsr = instr_word[15:9] == `CTX_OP_JSR;
  wire is_rts = instr_word[15:3] == `CTX_OP_RTS;
  wire is_sob = instr_word[15:9] == `CTX_OP_SOB;
  wire is_rti = instr_word == `CTX_OP_RTI || instr_word == `CTX_OP_RTT;
  wire [2:0] jmp_mode = instr_word[5:3];

  // register field sits low for return and jump, high otherwise
  wire [2:0] rsel = (is_rts | is_jmp) ? instr_word[2:0] : instr_word[8:6];
  wire [2:0] rd_sel = busy ? link_r : rsel;
  wire [15:0] gen_rdata;
  wire [15:0] reg_val = (rd_sel == 3'h6) ? sp :
                        (rd_sel == 3'h7) ? (busy ? pc : instr_pc) :
                        gen_rdata;

  // sign-extended byte offset, doubled
  wire [15:0] br_off = {{7{instr_word[7]}}, instr_word[7:0], 1'b0};
  // unsigned six-bit offset, doubled
  wire [15:0] sob_off = {9'h000, instr_word[5:0], 1'b0};
  wire [15:0] sob_dec = reg_val - 16'h0001;
  wire [15:0] sp_dn = sp - `CTX_WORD_STEP;
  wire [15:0] sp_up = sp + `CTX_WORD_STEP;

  reg gen_we;
  reg [2:0] gen_sel;
  reg [15:0] gen_wdata;

  always @* begin
    gen_we = 1'b0;
    gen_sel = link_r;
    gen_wdata = mem_rdata;
    if (take_instr && is_sob) begin
      gen_we = 1'b1;
      gen_sel = rsel;
      gen_wdata = sob_dec;
    end else if (acked && state_r == S_JSR_PUSH) begin
      gen_we = 1'b1;
      gen_wdata = pc;
    end else if (acked && state_r == S_RTS_POP) begin
      gen_we = 1'b1;
    end
  end

  ctx_regfile u_regs (
    .clock(clock),
    .reset_n(reset_n),
    .wr_en(gen_we),
    .wr_sel(gen_sel),
    .wr_data(gen_wdata),
    .rd_sel(rd_sel),
    .rd_data(gen_rdata)
  );

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= S_IDLE;
      tmp_r <= 16'h0000;
      vec_r <= 16'h0000;
      link_r <= 3'h0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 16'h0000;
      mem_wdata <= 16'h0000;
      busy <= 1'b0;
      done <= 1'b0;
      illegal <= 1'b0;
      pc <= `CTX_PC_RST;
      sp <= `CTX_SP_RST;
      psw <= `CTX_PSW_RST;
    end else begin
      done <= 1'b0;
      illegal <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (take_trap || (take_instr && is_jmp &&
              jmp_mode == `CTX_MODE_REG)) begin
            // trap entry: push status first, then pc
            vec_r <= take_trap ? trap_vec : `CTX_VEC_ILLEGAL;
            if (!take_trap) begin
              pc <= instr_pc;
              illegal <= 1'b1;
            end
            busy <= 1'b1;
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_addr <= sp_dn;
            mem_wdata <= psw;
            state_r <= S_TPUSH_PS;
          end else if (take_instr) begin
            if (is_blo) begin
              // same as branch on carry set, flags untouched
              pc <= psw[`CTX_C_BIT] ? instr_pc + br_off : instr_pc;
              done <= 1'b1;
            end else if (is_jmp) begin
              // deferred mode needs the register, not the ea input
              pc <= (jmp_mode == `CTX_MODE_DEFER) ? reg_val : dst_addr;
              done <= 1'b1;
            end else if (is_sob) begin
              if (rsel == 3'h6) begin
                sp <= sob_dec;
              end
              pc <= (sob_dec != 16'h0000) ? instr_pc - sob_off : instr_pc;
              done <= 1'b1;
            end else if (is_jsr) begin
              tmp_r <= dst_addr;
              pc <= instr_pc;
              link_r <= rsel;
              busy <= 1'b1;
              mem_req <= 1'b1;
              mem_we <= 1'b1;
              mem_addr <= sp_dn;
              mem_wdata <= reg_val;
              state_r <= S_JSR_PUSH;
            end else if (is_rts) begin
              pc <= reg_val;
              link_r <= rsel;
              busy <= 1'b1;
              mem_req <= 1'b1;
              mem_we <= 1'b0;
              mem_addr <= sp;
              state_r <= S_RTS_POP;
            end else if (is_rti) begin
              pc <= instr_pc;
              busy <= 1'b1;
              mem_req <= 1'b1;
              mem_we <= 1'b0;
              mem_addr <= sp;
              state_r <= S_POP_PC;
            end else begin
              // not ours: just step past it
              pc <= instr_pc;
              done <= 1'b1;
            end
          end
        end
        S_TPUSH_PS: begin
          if (mem_ack) begin
            sp <= sp_dn;
            mem_addr <= sp - 16'h0004;
            mem_wdata <= pc;
            state_r <= S_TPUSH_PC;
          end
        end
        S_TPUSH_PC: begin
          if (mem_ack) begin
            sp <= sp_dn;
            mem_we <= 1'b0;
            mem_addr <= vec_r;
            state_r <= S_VEC_PC;
          end
        end
        S_VEC_PC: begin
          if (mem_ack) begin
            pc <= mem_rdata;
            mem_addr <= vec_r + `CTX_WORD_STEP;
            state_r <= S_VEC_PS;
          end
        end
        S_VEC_PS: begin
          if (mem_ack) begin
            psw <= mem_rdata;
            mem_req <= 1'b0;
            busy <= 1'b0;
            done <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        S_POP_PC: begin
          if (mem_ack) begin
            pc <= mem_rdata;
            sp <= sp_up;
            mem_addr <= sp_up;
            state_r <= S_POP_PS;
          end
        end
        S_POP_PS: begin
          if (mem_ack) begin
            psw <= mem_rdata;
            sp <= sp_up;
            mem_req <= 1'b0;
            busy <= 1'b0;
            done <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        S_JSR_PUSH: begin
          if (mem_ack) begin
            // link register set to pc, then pc from temp
            sp <= (link_r == 3'h6) ? pc : sp_dn;
            pc <= tmp_r;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            busy <= 1'b0;
            done <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        S_RTS_POP: begin
          if (mem_ack) begin
            sp <= (link_r == 3'h6) ? mem_rdata : sp_up;
            if (link_r == 3'h7) begin
              pc <= mem_rdata;
            end
            mem_req <= 1'b0;
            busy <= 1'b0;
            done <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        default: begin
          state_r <= S_IDLE;
          mem_req <= 1'b0;
          busy <= 1'b0;
        end
      endcase
    end
  end
endmodule

// file: logic/ctx_regfile.v
`timescale 1ns/100ps
module ctx_regfile (
  // clock and reset
  input wire clock,
  input wire reset_n,
  // write port
  input wire wr_en,
  input wire [2:0] wr_sel,
  input wire [15:0] wr_data,
  // read port
  input wire [2:0] rd_sel,
  output wire [15:0] rd_data
);
  // general registers 0 to 5; stack pointer and pc live in the caller
  reg [15:0] regs_r [0:5];
  integer i;

  assign rd_data = (rd_sel < 3'h6) ? regs_r[rd_sel] : 16'h0000;

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (i = 0; i < 6; i = i + 1) begin
        regs_r[i] <= 16'h0000;
      end
    end else if (wr_en && wr_sel < 3'h6) begin
      regs_r[wr_sel] <= wr_data;
    end
  end
endmodule

// file: sim/ctx_exec_chk.sv
`timescale 1ns/100ps
module ctx_exec_chk (
  // clock
  input logic clock,
  input logic reset_n,
  // request
  input logic instr_valid,
  input logic [15:0] instr_word,
  input logic [15:0] instr_pc,
  input logic trap_req,
  // memory
  input logic mem_req,
  input logic mem_we,
  input logic [15:0] mem_addr,
  input logic [15:0] mem_wdata,
  // status
  input logic busy,
  input logic done,
  input logic illegal,
  input logic [15:0] pc,
  input logic [15:0] sp,
  input logic [15:0] psw
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire [15:0] w = instr_word;
  wire acc = instr_valid && !trap_req && !busy;
  wire branch_if_lower_unsigned = acc && w[15:8] == 8'h87;
  wire [15:0] bo = {{7{w[7]}}, w[7:0], 1'h0};
  wire [15:0] so = {9'h000, w[5:0], 1'h0};
  chk_blo_taken: assert property (branch_if_lower_unsigned && psw[0] |=>
    pc == $past(instr_pc) + $past(bo)) else $error("blo pc");
  chk_blo_idle: assert property (branch_if_lower_unsigned && !psw[0] |=>
    done && pc == $past(instr_pc) && $stable(psw)) else $error("blo c");
  chk_jmp_trap: assert property (acc && w[15:3] == 13'h0008 |=>
    illegal) else $error("jmp r");
  chk_call_push: assert property (acc && w[15:9] == 7'h04 |=>
    mem_req && mem_we && pc == $past(instr_pc)) else $error("jsr");
  chk_ret_pop: assert property (acc && w[15:3] == 13'h0010 |=>
    mem_req && !mem_we && mem_addr == $past(sp)) else $error("rts");
  chk_sob_step: assert property (acc && w[15:9] == 7'h3F |=>
    done && (pc == $past(instr_pc) || pc == $past(instr_pc) - $past(so)))
    else $error("sob");
  chk_trap_push: assert property (trap_req && !busy |=> mem_req &&
    mem_addr == $past(sp) - 16'h0002 && mem_wdata == $past(psw))
    else $error("trap");
  chk_push_pre: assert property (mem_req && mem_we |->
    mem_addr == sp - 16'h0002) else $error("push");
  cover property (branch_if_lower_unsigned && psw[0]);
  cover property (illegal);
  cover property (trap_req && !busy);
endmodule

bind ctx_exec ctx_exec_chk i_ctx_exec_chk (.clock, .reset_n, .instr_valid,
  .instr_word, .instr_pc, .trap_req, .mem_req, .mem_we, .mem_addr, .mem_wdata,
  .busy, .done, .illegal, .pc, .sp, .psw);

// file: sim/ctx_exec_tb_top.sv
`timescale 1ns/100ps
module ctx_exec_tb_top;
  logic clock, reset_n, instr_valid, trap_req, mem_req, mem_we, mem_ack;
  logic busy, done, illegal, ill_seen;
  logic [3:0] lag;
  logic [15:0] instr_word, instr_pc, dst_addr, trap_vec, mem_addr, mem_wdata;
  logic [15:0] mem_rdata, pc, sp, psw, s0, p0, f0;
  int fails = 0;
  int cmp_count = 0;
  ctx_exec i_ctx_exec (.clock, .reset_n, .instr_valid, .instr_word,
    .instr_pc, .dst_addr, .trap_req, .trap_vec, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .mem_rdata, .mem_ack, .busy, .done, .illegal, .pc, .sp, .psw);
  ctx_mem_model i_ctx_mem_model (.clock, .reset_n, .lag, .mem_req, .mem_we,
    .mem_addr, .mem_wdata, .mem_rdata, .mem_ack);
  initial begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end
  always @(negedge clock) if (illegal === 1'h1) ill_seen <= 1'h1;
  function automatic logic [15:0] m(input logic [15:0] a);
    return i_ctx_mem_model.mem[a[15:1]];
  endfunction
  task automatic cmp(input string n, input logic [15:0] e, s);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic end_of_test;
    if (fails == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // offer one request, then wait for its done pulse
  task automatic run(input logic t, input logic [15:0] w, a, d);
    @(posedge clock);
    trap_req <= t;
    instr_valid <= !t;
    instr_word <= w;
    instr_pc <= a;
    dst_addr <= d;
    trap_vec <= d;
    @(posedge clock);
    trap_req <= 1'h0;
    instr_valid <= 1'h0;
    for (int i = 0; i < 40 && done !== 1'h1; i++) @(negedge clock);
    cmp("done", 16'h0001, {15'h0000, done});
  endtask
  task automatic t_trap(input logic [15:0] ret);
    run(1'h0, 16'h87FE, 16'h0100, 16'h0000);
    cmp("blo idle", 16'h0100, pc);
    s0 = sp;
    p0 = pc;
    f0 = psw;
    run(1'h1, 16'h0000, 16'h0000, 16'h0030);
    cmp("trap pc", 16'h1000, pc);
    cmp("trap psw", 16'h0001, psw);
    cmp("trap sp", s0 - 16'h0004, sp);
    cmp("push psw", f0, m(s0 - 16'h0002));
    cmp("push pc", p0, m(s0 - 16'h0004));
    run(1'h0, 16'h87FE, 16'h0200, 16'h0000);
    cmp("blo back", 16'h01FC, pc);
    run(1'h0, ret, 16'h0300, 16'h0000);
    cmp("ret pc", p0, pc);
    cmp("ret psw", f0, psw);
    cmp("ret sp", s0, sp);
  endtask
  task automatic t_jmp;
    s0 = sp;
    ill_seen = 1'h0;
    run(1'h0, 16'h0042, 16'h0400, 16'h0000);
    cmp("illegal", 16'h0001, {15'h0000, ill_seen});
    cmp("ill pc", 16'h2000, pc);
    cmp("ill push", 16'h0400, m(s0 - 16'h0004));
    run(1'h0, 16'h005F, 16'h0402, 16'h0A00);
    cmp("jmp pc", 16'h0A00, pc);
  endtask
  task automatic t_call;
    s0 = sp;
    run(1'h0, 16'h081F, 16'h0600, 16'h3000);
    cmp("call pc", 16'h3000, pc);
    cmp("call sp", s0 - 16'h0002, sp);
    cmp("link push", 16'h0000, m(s0 - 16'h0002));
    run(1'h0, 16'h0048, 16'h3002, 16'h0000);
    cmp("link", 16'h0600, pc);
    run(1'h0, 16'h0080, 16'h0602, 16'h0000);
    cmp("rts pc", 16'h0600, pc);
    cmp("rts sp", s0, sp);
  endtask
  task automatic t_loop;
    run(1'h0, 16'h7E03, 16'h0700, 16'h0000);
    cmp("sob back", 16'h06FA, pc);
    i_ctx_mem_model.mem[sp[15:1]] = 16'h0001;
    run(1'h0, 16'h0081, 16'h0702, 16'h0000);
    run(1'h0, 16'h7E7F, 16'h0800, 16'h0000);
    cmp("sob out", 16'h0800, pc);
    run(1'h0, 16'h7E3F, 16'h0900, 16'h0000);
    cmp("sob max", 16'h0882, pc);
  endtask
  initial begin
    {instr_valid, trap_req, instr_word, instr_pc, dst_addr, trap_vec} = '0;
    {reset_n, ill_seen, lag} = '0;
    i_ctx_mem_model.mem[16'h0002] = 16'h2000;
    i_ctx_mem_model.mem[16'h0003] = 16'h0000;
    i_ctx_mem_model.mem[16'h0018] = 16'h1000;
    i_ctx_mem_model.mem[16'h0019] = 16'h0001;
    repeat (12) @(posedge clock);
    reset_n <= 1'h1;
    t_trap(16'h0002);
    lag = 4'h3;
    t_trap(16'h0006);
    t_jmp;
    t_call;
    lag = 4'h0;
    t_loop;
    end_of_test;
  end
  initial begin
    repeat (3000) @(posedge clock);
    fails++;
    end_of_test;
  end
endmodule

// file: sim/ctx_mem_model.sv
`timescale 1ns/100ps
module ctx_mem_model (
  // clock
  input logic clock,
  input logic reset_n,
  // request
  input logic [3:0] lag,
  input logic mem_req,
  input logic mem_we,
  input logic [15:0] mem_addr,
  input logic [15:0] mem_wdata,
  // answer
  output logic [15:0] mem_rdata,
  output logic mem_ack
);
  // word store; byte bit 0 dropped, code sits on even bytes
  logic [15:0] mem [0:32767];
  logic [3:0] cnt_r;
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= 4'h0;
      mem_ack <= 1'h0;
      mem_rdata <= 16'h5A5A;
    end else if (mem_req && !mem_ack && cnt_r >= lag) begin
      cnt_r <= 4'h0;
      mem_ack <= 1'h1;
      if (mem_we) mem[mem_addr[15:1]] <= mem_wdata;
      else mem_rdata <= mem[mem_addr[15:1]];
    end else begin
      // stale data flips so a late sample shows
      mem_rdata <= ~mem_rdata;
      mem_ack <= 1'h0;
      if (mem_req && !mem_ack) cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule
